// File: nvmrap_pkg.sv
// Shared constants for the non-volatile memory read access port
package nvmrap_pkg;
	localparam int         DATA_W       = 8;
	localparam int         WORD_W       = 14;
	localparam int         ADDR_W       = 16;
	localparam int         REG_AW       = 3;
	localparam logic [2:0] CTRL_OFF     = 3'h0;
	localparam logic [2:0] ADDR_LO_OFF  = 3'h1;
	localparam logic [2:0] ADDR_HI_OFF  = 3'h2;
	localparam logic [2:0] DATA_LO_OFF  = 3'h3;
	localparam logic [2:0] DATA_HI_OFF  = 3'h4;
	localparam int         RD_BIT       = 0;
	localparam int         WR_BIT       = 1;
	localparam int         ERR_BIT      = 3;
	localparam int         REGS_BIT     = 6;
	localparam int         IND_PFM_BIT  = 15;
	localparam logic [15:0] CFG_RO_BASE = 16'h0030;
	localparam logic [15:0] DEV_ID_IDX  = 16'h0030;
	localparam logic [15:0] REV_IDX     = 16'h0031;
	localparam logic [7:0]  BYTE_RST    = 8'h00;
	localparam logic [13:0] WORD_RST    = 14'h0000;
endpackage

// File: nvmrap_mem_if.sv
// Memory access signals between the control logic and the storage array
`timescale 1ns/1ps
interface nvmrap_mem_if;
	logic        rsel;
	logic [15:0] raddr;
	logic [13:0] rdata;
	logic        we;
	logic        wsel;
	logic [15:0] waddr;
	logic [13:0] wdata;
	modport ctl (output rsel, output raddr, input rdata, output we, output wsel, output waddr, output wdata);
	modport mem (input rsel, input raddr, output rdata, input we, input wsel, input waddr, input wdata);
endinterface

// File: nvmrap_mem.sv
// Flip-flop storage for program memory and the user ID, EEPROM and configuration region
`timescale 1ns/1ps
module nvmrap_mem #(
	parameter int          PFM_AW  = 8,
	parameter int          CFG_AW  = 6,
	parameter logic [13:0] DEV_ID  = 14'h0a5a, // Arbitrary identification value
	parameter logic [13:0] DEV_REV = 14'h0001  // Arbitrary revision value
) (
	input  wire logic  sys_clk,
	input  wire logic  nrst,
	nvmrap_mem_if.mem  mif
);
	logic [13:0] pfm_reg [2**PFM_AW];
	logic [13:0] cfg_reg [2**CFG_AW];

	wire [PFM_AW-1:0] pfm_ridx = mif.raddr[PFM_AW-1:0];
	wire [CFG_AW-1:0] cfg_ridx = mif.raddr[CFG_AW-1:0];
	wire [PFM_AW-1:0] pfm_widx = mif.waddr[PFM_AW-1:0];
	wire [CFG_AW-1:0] cfg_widx = mif.waddr[CFG_AW-1:0];
	wire              is_id    = mif.raddr == nvmrap_pkg::DEV_ID_IDX;
	wire              is_rev   = mif.raddr == nvmrap_pkg::REV_IDX;
	wire [13:0]       cfg_word = is_id ? DEV_ID : (is_rev ? DEV_REV : cfg_reg[cfg_ridx]);

	assign mif.rdata = mif.rsel ? cfg_word : pfm_reg[pfm_ridx];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 2**PFM_AW; i++) begin
				pfm_reg[i] <= nvmrap_pkg::WORD_RST;
			end
			for (int j = 0; j < 2**CFG_AW; j++) begin
				cfg_reg[j] <= nvmrap_pkg::WORD_RST;
			end
		end else if (mif.we && mif.wsel) begin
			cfg_reg[cfg_widx] <= mif.wdata;
		end else if (mif.we) begin
			pfm_reg[pfm_widx] <= mif.wdata;
		end
	end
endmodule

// File: nvmrap_top.sv
// Read access port for on-chip non-volatile memory: indirect reads and register interface
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module nvmrap_top #(
	parameter int PFM_AW = 8,
	parameter int CFG_AW = 6
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        ind_rd,
	input  wire logic        ind_wr,
	input  wire logic [15:0] ind_addr,
	output logic      [7:0]  ind_rdata,
	output logic             cpu_stall,
	input  wire logic [2:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        write_protect
);
	nvmrap_mem_if mif ();

	logic        wp_s1_reg;
	logic        wp_s2_reg;
	logic        rd_bit_reg;
	logic        wr_bit_reg;
	logic        err_reg;
	logic        region_reg;
	logic [7:0]  addr_lo_reg;
	logic [7:0]  addr_hi_reg;
	logic [7:0]  data_lo_reg;
	logic [5:0]  data_hi_reg;
	logic [7:0]  ind_rdata_reg;
	logic        stall_reg;
	logic [7:0]  rdata_reg;

	// Register decode
	wire         ctrl_wr    = reg_wr && (reg_addr == nvmrap_pkg::CTRL_OFF);
	wire         alo_wr     = reg_wr && (reg_addr == nvmrap_pkg::ADDR_LO_OFF);
	wire         ahi_wr     = reg_wr && (reg_addr == nvmrap_pkg::ADDR_HI_OFF);
	wire         dlo_wr     = reg_wr && (reg_addr == nvmrap_pkg::DATA_LO_OFF);
	wire         dhi_wr     = reg_wr && (reg_addr == nvmrap_pkg::DATA_HI_OFF);
	wire         busy       = rd_bit_reg || wr_bit_reg;
	wire         rd_start   = ctrl_wr && reg_wdata[nvmrap_pkg::RD_BIT] && !busy;
	// A request with both strobes set is taken as a read; the write is dropped
	wire         wr_start   = ctrl_wr && reg_wdata[nvmrap_pkg::WR_BIT] && !reg_wdata[nvmrap_pkg::RD_BIT] && !busy;
	wire [15:0]  nvm_addr   = {addr_hi_reg, addr_lo_reg};
	wire         ro_target  = region_reg && (nvm_addr >= nvmrap_pkg::CFG_RO_BASE);
	wire         wr_blocked = wp_s2_reg || ro_target;
	// Indirect reads are refused while the CPU is held for a register fetch
	wire         ind_rd_ok  = ind_rd && !rd_bit_reg;
	wire [13:0]  data_word  = {data_hi_reg, data_lo_reg};

	// Register fetch owns the read port in its cycle; otherwise the pointer drives it
	assign mif.rsel  = rd_bit_reg ? region_reg : !ind_addr[nvmrap_pkg::IND_PFM_BIT];
	assign mif.raddr = rd_bit_reg ? nvm_addr : {1'b0, ind_addr[14:0]};
	// Only the register interface can write; indirect stores have no path here
	assign mif.we    = wr_bit_reg && !wr_blocked;
	assign mif.wsel  = region_reg;
	assign mif.waddr = nvm_addr;
	assign mif.wdata = data_word;

	wire [7:0] ctrl_val = (8'(region_reg) << nvmrap_pkg::REGS_BIT) | (8'(err_reg) << nvmrap_pkg::ERR_BIT)
		| (8'(wr_bit_reg) << nvmrap_pkg::WR_BIT) | (8'(rd_bit_reg) << nvmrap_pkg::RD_BIT);
	wire [7:0] rd_mux = (reg_addr == nvmrap_pkg::CTRL_OFF)    ? ctrl_val :
		(reg_addr == nvmrap_pkg::ADDR_LO_OFF) ? addr_lo_reg :
		(reg_addr == nvmrap_pkg::ADDR_HI_OFF) ? addr_hi_reg :
		(reg_addr == nvmrap_pkg::DATA_LO_OFF) ? data_lo_reg :
		(reg_addr == nvmrap_pkg::DATA_HI_OFF) ? {2'b00, data_hi_reg} : nvmrap_pkg::BYTE_RST;

	// Hardware set beats a software clear in the same cycle; software can only clear
	wire err_next = (wr_bit_reg && wr_blocked) ? 1'b1 :
		(ctrl_wr ? (err_reg && reg_wdata[nvmrap_pkg::ERR_BIT]) : err_reg);

	nvmrap_mem #(
		.PFM_AW (PFM_AW),
		.CFG_AW (CFG_AW)
	) u_mem (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.mif     (mif.mem)
	);

	// Protect pin is asynchronous; writes stay blocked until it has been sampled twice
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wp_s1_reg <= 1'b1;
			wp_s2_reg <= 1'b1;
		end else begin
			wp_s1_reg <= write_protect;
			wp_s2_reg <= wp_s1_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_bit_reg <= 1'b0;
			wr_bit_reg <= 1'b0;
			err_reg    <= 1'b0;
			region_reg <= 1'b0;
			stall_reg  <= 1'b0;
		end else begin
			rd_bit_reg <= rd_start;
			wr_bit_reg <= wr_start;
			err_reg    <= err_next;
			region_reg <= ctrl_wr ? reg_wdata[nvmrap_pkg::REGS_BIT] : region_reg;
			stall_reg  <= rd_start || ind_rd_ok;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			addr_lo_reg <= nvmrap_pkg::BYTE_RST;
			addr_hi_reg <= nvmrap_pkg::BYTE_RST;
		end else begin
			addr_lo_reg <= alo_wr ? reg_wdata : addr_lo_reg;
			addr_hi_reg <= ahi_wr ? reg_wdata : addr_hi_reg;
		end
	end

	// Fetch wins over a software write to the data pair in the same cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			data_lo_reg <= nvmrap_pkg::BYTE_RST;
			data_hi_reg <= nvmrap_pkg::WORD_RST[13:8];
		end else if (rd_bit_reg) begin
			data_lo_reg <= mif.rdata[7:0];
			data_hi_reg <= mif.rdata[13:8];
		end else begin
			data_lo_reg <= dlo_wr ? reg_wdata : data_lo_reg;
			data_hi_reg <= dhi_wr ? reg_wdata[5:0] : data_hi_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ind_rdata_reg <= nvmrap_pkg::BYTE_RST;
			rdata_reg     <= nvmrap_pkg::BYTE_RST;
		end else begin
			ind_rdata_reg <= ind_rd_ok ? mif.rdata[7:0] : ind_rdata_reg;
			rdata_reg     <= reg_rd ? rd_mux : rdata_reg;
		end
	end

	assign ind_rdata = ind_rdata_reg;
	assign cpu_stall = stall_reg;
	assign reg_rdata = rdata_reg;

	ind_stall_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		ind_rd_ok |=> cpu_stall) else $error("indirect read did not stall");
	stall_cause_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		cpu_stall |-> $past(ind_rd_ok) || $past(rd_start)) else $error("stall without a read");
	ind_data_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		ind_rd_ok |=> ind_rdata == $past(mif.rdata[7:0])) else $error("indirect byte wrong");
	ind_store_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		ind_wr && !wr_bit_reg |-> !mif.we) else $error("indirect store wrote memory");
	store_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		ind_wr && !ind_rd_ok && !rd_start && !wr_bit_reg && !ctrl_wr |=> !cpu_stall && $stable(err_reg))
		else $error("indirect store stalled or flagged");
	rd_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		rd_start |=> rd_bit_reg ##1 !rd_bit_reg) else $error("read strobe did not self-clear");
	fetch_data_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		rd_bit_reg |=> data_word == $past(mif.rdata)) else $error("data pair not loaded");
	data_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!rd_bit_reg && !dlo_wr && !dhi_wr |=> $stable(data_word)) else $error("data pair changed");
	wp_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		wr_bit_reg && wp_s2_reg |-> !mif.we ##1 err_reg) else $error("protected write not blocked");
	ro_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		mif.we |-> !(mif.wsel && mif.waddr >= nvmrap_pkg::CFG_RO_BASE)) else $error("read-only area written");
	wr_go_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		wr_bit_reg && !wr_blocked |-> mif.we) else $error("allowed write dropped");
	// A stall never outlives the read that caused it
	stall_once_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		cpu_stall && !ind_rd_ok && !rd_start |=> !cpu_stall) else $error("stall lasted too long");
	ind_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!ind_rd_ok |=> $stable(ind_rdata)) else $error("indirect byte changed without a read");
	// The fetch cycle owns the memory port alone
	fetch_stall_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		rd_bit_reg |-> cpu_stall) else $error("fetch did not stall");
	fetch_alone_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		rd_bit_reg |-> !wr_bit_reg && !mif.we) else $error("fetch overlapped a write");
	// Software writes to the data pair land unless a fetch takes the cycle
	lo_data_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		dlo_wr && !rd_bit_reg |=> data_lo_reg == $past(reg_wdata)) else $error("data low write lost");
	hi_data_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		dhi_wr && !rd_bit_reg |=> {2'b00, data_hi_reg} == ($past(reg_wdata) & 8'h3f))
		else $error("data high write lost");
	// Error flag is sticky and only a written zero clears it
	err_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		ctrl_wr && !reg_wdata[nvmrap_pkg::ERR_BIT] && !wr_bit_reg |=> !err_reg)
		else $error("error flag not cleared");
	err_sticky_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		err_reg && !ctrl_wr |=> err_reg) else $error("error flag dropped");
	// Read data holds between register reads
	rdata_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!reg_rd |=> $stable(reg_rdata)) else $error("read data changed without a read");
	reg_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		reg_rd |=> reg_rdata == $past(rd_mux)) else $error("register read data wrong");
	unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		reg_rd && (reg_addr > nvmrap_pkg::DATA_HI_OFF) |=> reg_rdata == nvmrap_pkg::BYTE_RST) else $error("unmapped read");

	ind_read_c: cover property (@(posedge sys_clk) disable iff (!nrst) ind_rd_ok ##1 cpu_stall);
	reg_read_c: cover property (@(posedge sys_clk) disable iff (!nrst) rd_start ##1 rd_bit_reg ##1 reg_rd);
	blocked_c: cover property (@(posedge sys_clk) disable iff (!nrst) wr_bit_reg && wr_blocked ##1 err_reg);
	store_c: cover property (@(posedge sys_clk) disable iff (!nrst) ind_wr && !ind_rd);
	err_clear_c: cover property (@(posedge sys_clk) disable iff (!nrst) err_reg ##1 !err_reg);
endmodule

// File: nvmrap_cpu.sv
// CPU core model issuing register-interface and indirect accesses
`timescale 1ns/1ps
module nvmrap_cpu (
	input  wire logic        sys_clk,
	output logic             ind_rd,
	output logic             ind_wr,
	output logic      [15:0] ind_addr,
	output logic      [2:0]  reg_addr,
	output logic      [7:0]  reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [7:0]  reg_rdata,
	input  wire logic [7:0]  ind_rdata,
	input  wire logic        cpu_stall
);
	logic [1:0] st;
	initial begin
		{ind_rd, ind_wr, reg_wr, reg_rd} = 4'h0;
		ind_addr = 16'h0000;
		reg_addr = 3'h7;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// Released data bus must not keep the last value
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic setup(input logic r, input logic [15:0] a);
		wr(nvmrap_pkg::CTRL_OFF, {1'b0, r, 6'h00});
		wr(nvmrap_pkg::ADDR_LO_OFF, a[7:0]);
		wr(nvmrap_pkg::ADDR_HI_OFF, a[15:8]);
	endtask
	task automatic pwrite(input logic r, input logic [15:0] a, input logic [13:0] w);
		setup(r, a);
		wr(nvmrap_pkg::DATA_LO_OFF, w[7:0]);
		wr(nvmrap_pkg::DATA_HI_OFF, {2'b00, w[13:8]});
		wr(nvmrap_pkg::CTRL_OFF, {1'b0, r, 6'h02});
	endtask
	task automatic fetch(input logic r, input logic [15:0] a, output logic [13:0] w);
		logic [7:0] lo;
		logic [7:0] hi;
		setup(r, a);
		wr(nvmrap_pkg::CTRL_OFF, {1'b0, r, 6'h01});
		#1 st[0] = cpu_stall;
		@(posedge sys_clk);
		#1 st[1] = cpu_stall;
		rd(nvmrap_pkg::DATA_LO_OFF, lo);
		rd(nvmrap_pkg::DATA_HI_OFF, hi);
		w = {hi[5:0], lo};
	endtask
	task automatic ind(input logic store, input logic [15:0] a, output logic [7:0] b);
		@(posedge sys_clk);
		ind_addr <= a;
		if (store) ind_wr <= 1'b1;
		else ind_rd <= 1'b1;
		@(posedge sys_clk);
		ind_rd <= 1'b0;
		ind_wr <= 1'b0;
		ind_addr <= ~a;
		#1 b = ind_rdata;
		st[0] = cpu_stall;
		@(posedge sys_clk);
		#1 st[1] = cpu_stall;
	endtask
endmodule

// File: nvm_read_access_port_bench.sv
// Self-checking bench for the non-volatile memory read access port
`timescale 1ns/1ps
module nvm_read_access_port_bench;
	logic        sys_clk, nrst, write_protect, ind_rd, ind_wr, reg_wr, reg_rd, cpu_stall;
	logic [15:0] ind_addr;
	logic [2:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, ind_rdata, b;
	logic [13:0] w;
	int          n_errors = 0;
	int          tests_run = 0;
	nvmrap_top #(.PFM_AW(8), .CFG_AW(6)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .ind_rd(ind_rd),
		.ind_wr(ind_wr), .ind_addr(ind_addr), .ind_rdata(ind_rdata), .cpu_stall(cpu_stall),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .write_protect(write_protect));
	nvmrap_cpu cpu_u (.sys_clk(sys_clk), .ind_rd(ind_rd), .ind_wr(ind_wr), .ind_addr(ind_addr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ind_rdata(ind_rdata), .cpu_stall(cpu_stall));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic t_fetch();
		cpu_u.pwrite(1'b0, 16'h0012, 14'h1abc);
		cpu_u.pwrite(1'b0, 16'h0013, 14'h0155);
		cpu_u.fetch(1'b0, 16'h0012, w);
		chk("fetch word", w, 16'h1abc);
		chk("fetch stall", cpu_u.st, 16'h0001);
		cpu_u.rd(nvmrap_pkg::CTRL_OFF, b);
		chk("read strobe", b[0], 16'h0000);
		cpu_u.rd(3'h5, b);
		chk("unmapped", b, 16'h0000);
		cpu_u.fetch(1'b0, 16'h0013, w);
		chk("second fetch", w, 16'h0155);
	endtask
	task automatic t_ind();
		cpu_u.ind(1'b0, 16'h8012, b);
		chk("ind byte", b, 16'h00bc);
		chk("ind stall", cpu_u.st, 16'h0001);
		cpu_u.ind(1'b1, 16'h8012, b);
		chk("store stall", cpu_u.st, 16'h0000);
		cpu_u.ind(1'b0, 16'h8012, b);
		chk("after store", b, 16'h00bc);
		cpu_u.rd(nvmrap_pkg::CTRL_OFF, b);
		chk("store err", b[3], 16'h0000);
		cpu_u.rd(nvmrap_pkg::DATA_LO_OFF, b);
		chk("data held", b, 16'h0055);
		cpu_u.wr(nvmrap_pkg::DATA_LO_OFF, 8'h3c);
		cpu_u.rd(nvmrap_pkg::DATA_LO_OFF, b);
		chk("data written", b, 16'h003c);
	endtask
	task automatic t_protect();
		@(posedge sys_clk);
		write_protect <= 1'b1;
		repeat (3) @(posedge sys_clk);
		cpu_u.pwrite(1'b0, 16'h0012, 14'h2222);
		cpu_u.rd(nvmrap_pkg::CTRL_OFF, b);
		chk("protect err", b[3], 16'h0001);
		cpu_u.fetch(1'b0, 16'h0012, w);
		chk("protected word", w, 16'h1abc);
		@(posedge sys_clk);
		write_protect <= 1'b0;
		repeat (3) @(posedge sys_clk);
		cpu_u.pwrite(1'b1, 16'h0005, 14'h0777);
		cpu_u.fetch(1'b1, 16'h0005, w);
		chk("config word", w, 16'h0777);
		cpu_u.pwrite(1'b1, 16'h0030, 14'h1111);
		cpu_u.rd(nvmrap_pkg::CTRL_OFF, b);
		chk("read-only err", b[3], 16'h0001);
		cpu_u.wr(nvmrap_pkg::CTRL_OFF, 8'h08);
		cpu_u.rd(nvmrap_pkg::CTRL_OFF, b);
		chk("err kept", b[3], 16'h0001);
		cpu_u.wr(nvmrap_pkg::CTRL_OFF, 8'h00);
		cpu_u.rd(nvmrap_pkg::CTRL_OFF, b);
		chk("err clear", b[3], 16'h0000);
		cpu_u.fetch(1'b1, 16'h0030, w);
		chk("id word", w, 16'h0a5a);
	endtask
	initial begin
		nrst <= 1'b0;
		write_protect <= 1'b0;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		cpu_u.rd(nvmrap_pkg::CTRL_OFF, b);
		chk("ctrl reset", b, 16'h0000);
		t_fetch();
		t_ind();
		t_protect();
		complete_run();
	end
	// Whole run needs fewer than two hundred cycles
	initial begin
		#200000;
		n_errors++;
		complete_run();
	end
endmodule
